// file: src/ascfg_pkg.sv
// Constants for the auxiliary converter step eight configuration register
package ascfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  STEP8_CFG_INDEX = 8'h98;
  localparam logic [11:0] STEP8_CFG_ADDR  = {2'h0, STEP8_CFG_INDEX, 2'h0};
  localparam logic [15:0] STEP8_CFG_RESET = 16'h0008;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT   = 15;
  localparam int GAIN_HI      = 14;
  localparam int GAIN_LO      = 13;
  localparam int RSVD_HI      = 12;
  localparam int RSVD_LO      = 5;
  localparam int NEG_BIT      = 4;
  localparam int POS_HI       = 3;
  localparam int POS_LO       = 0;
  localparam logic [15:0] WRITABLE_MASK = 16'he01f;

  // ----------------------------------------------------------------
  // Gain codes and decoded gain
  // ----------------------------------------------------------------
  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
  localparam logic [1:0] GAIN_X1      = 2'h0;
  localparam logic [1:0] GAIN_X2      = 2'h1;
  localparam logic [1:0] GAIN_X4      = 2'h2;

  // ----------------------------------------------------------------
  // Positive select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] POS_EXT_LAST   = 4'h7;
  localparam logic [3:0] POS_TEMP       = 4'h8;
  localparam logic [3:0] POS_SHORT      = 4'h9;
  localparam logic [3:0] POS_TEST_DAC   = 4'ha;
  localparam logic [3:0] POS_AVDD_DIV4  = 4'hb;
  localparam logic [3:0] POS_IOVDD_DIV4 = 4'hc;
  localparam logic [3:0] POS_DVDD_DIV2  = 4'hd;
  localparam logic [3:0] POS_ANALOG_PWR_DIV  = 4'he;
  localparam logic [3:0] POS_DIGITAL_PWR_DIV = 4'hf;

endpackage

// file: src/ascfg_step8_config.sv
// APB register and decode for auxiliary converter sequencer step eight
// What this block does
// - Step eight joins the converter sequence only while bit 15 is one, else it is skipped.
// - Bits 14:13 set the step gain: 00 gives 1, 01 gives 2, 10 and 11 both give 4.
// - Bits 12:5 always read as zero whatever was written.
// - Bit 4 routes the negative input: 0 to converter analog ground, 1 to external input seven.
// - Positive select codes 0000 to 0111 connect external inputs zero to seven.
// - Code 1000 is the temperature sensor, 1001 an internal short, 1010 the test DAC.
// - Code 1011 is analog supply over 4, 1110 analog power over 103, 1111 digital power over 103.
// - For positive codes 1000 and up the negative input is automatic and bit 4 is ignored.
// - The register sits at 98h and resets to 0008h: disabled, gain 1, temperature sensor.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps

module ascfg_step8_config
  import ascfg_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             stepEnable,
  output logic [1:0]       gainSelect,
  output logic             negAuto,
  output logic             negExtSeven,
  output logic [15:0]      posRoute
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] cfg_ff;
  logic [15:0] nxt_cfg;
  logic        ready_ff;
  logic        nxt_ready;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        err_ff;
  logic        nxt_err;
  logic        enable_ff;
  logic        nxt_enable;
  logic [1:0]  gain_ff;
  logic [1:0]  nxt_gain;
  logic        negAuto_ff;
  logic        nxt_negAuto;
  logic        negSeven_ff;
  logic        nxt_negSeven;
  logic [15:0] posRoute_ff;
  logic [15:0] nxt_posRoute;

  logic        hit;
  logic        finish;
  logic [15:0] laneMask;

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  // Registered pready costs one cycle but keeps every output on a flop
  assign hit    = (paddr == STEP8_CFG_ADDR);
  assign finish = psel && penable && ready_ff;
  assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    nxt_ready = psel && penable && !ready_ff;
    nxt_rdata = rdata_ff;
    nxt_err   = err_ff;
    nxt_cfg   = cfg_ff;
    if (psel && penable && !ready_ff) begin
      nxt_err = !hit;
      nxt_rdata = (hit && !pwrite) ? {16'h0000, cfg_ff & WRITABLE_MASK} : 32'h0000_0000;
    end
    if (finish && pwrite && hit) begin
      nxt_cfg = ((cfg_ff & ~laneMask) | (pwdata[15:0] & laneMask)) & WRITABLE_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff   <= STEP8_CFG_RESET;
      ready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      err_ff   <= 1'b0;
    end else begin
      cfg_ff   <= nxt_cfg;
      ready_ff <= nxt_ready;
      rdata_ff <= nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Decoded from the next value so outputs track the register exactly
  always_comb begin
    nxt_enable = nxt_cfg[ENABLE_BIT];
    unique case (nxt_cfg[GAIN_HI:GAIN_LO])
      GAIN_CODE_X1: nxt_gain = GAIN_X1;
      GAIN_CODE_X2: nxt_gain = GAIN_X2;
      default:      nxt_gain = GAIN_X4;
    endcase
    nxt_negAuto  = (nxt_cfg[POS_HI:POS_LO] > POS_EXT_LAST);
    nxt_negSeven = nxt_cfg[NEG_BIT] && !nxt_negAuto;
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gPos
      assign nxt_posRoute[g] = (nxt_cfg[POS_HI:POS_LO] == 4'(g));
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff   <= 1'b0;
      gain_ff     <= GAIN_X1;
      negAuto_ff  <= 1'b1;
      negSeven_ff <= 1'b0;
      posRoute_ff <= 16'h0100;
    end else begin
      enable_ff   <= nxt_enable;
      gain_ff     <= nxt_gain;
      negAuto_ff  <= nxt_negAuto;
      negSeven_ff <= nxt_negSeven;
      posRoute_ff <= nxt_posRoute;
    end
  end

  assign pready      = ready_ff;
  assign prdata      = rdata_ff;
  assign pslverr     = err_ff;
  assign stepEnable  = enable_ff;
  assign gainSelect  = gain_ff;
  assign negAuto     = negAuto_ff;
  assign negExtSeven = negSeven_ff;
  assign posRoute    = posRoute_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_enable_follows: assert property (@(posedge clock) disable iff (!rst_n)
    finish && pwrite && hit && pstrb[1] |=> stepEnable == $past(pwdata[15]))
    else $error("Step enable did not follow bit 15");

  a_gain_map: assert property (@(posedge clock) disable iff (!rst_n)
    finish && pwrite && hit && pstrb[1] && pwdata[14]
    |=> gainSelect == GAIN_X4 ##1 gainSelect == GAIN_X4 || $past(finish && pwrite))
    else $error("Gain codes 10 and 11 must give gain 4");

  a_gain_unity: assert property (@(posedge clock) disable iff (!rst_n)
    gainSelect == GAIN_X1 |-> cfg_ff[GAIN_HI:GAIN_LO] == GAIN_CODE_X1)
    else $error("Gain 1 without code 00");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
    pready && !pslverr |-> prdata[31:5] == {16'h0000, prdata[15:13], 8'h00})
    else $error("Reserved bits read nonzero");

  a_neg_seven: assert property (@(posedge clock) disable iff (!rst_n)
    negExtSeven |-> !posRoute[8] && !posRoute[15] && cfg_ff[NEG_BIT])
    else $error("Negative input seven without bit 4");

  a_pos_onehot: assert property (@(posedge clock) disable iff (!rst_n)
    $onehot(posRoute) && posRoute[cfg_ff[POS_HI:POS_LO]])
    else $error("Positive route not matching code");

  a_pos_internal: assert property (@(posedge clock) disable iff (!rst_n)
    posRoute[POS_TEMP] || posRoute[POS_SHORT] || posRoute[POS_TEST_DAC] |-> negAuto)
    else $error("Internal source without automatic negative");

  a_neg_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_ff[POS_HI] |-> negAuto && !negExtSeven)
    else $error("Bit 4 honoured for an internal source");

  a_reset_value: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> cfg_ff == STEP8_CFG_RESET)
    else $error("Register left reset with wrong value");

  a_ready_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("Ready must pulse for one cycle");

  // ----------------------------------------------------------------
  // Bus and decode cross checks
  // ----------------------------------------------------------------
  // Idle bus never sees a stray ready
  a_ready_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !psel |=> !pready)
    else $error("Ready raised without a select");

  a_ready_needs_sel: assert property (@(posedge clock) disable iff (!rst_n)
    pready |-> $past(psel && penable))
    else $error("Ready without an access phase");

  a_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
    finish && pwrite && hit |=> cfg_ff == ((($past(cfg_ff) & ~$past(laneMask))
      | ($past(pwdata[15:0]) & $past(laneMask))) & WRITABLE_MASK))
    else $error("Write did not land in the register");

  a_miss_no_write: assert property (@(posedge clock) disable iff (!rst_n)
    finish && !hit |=> $stable(cfg_ff))
    else $error("Unmapped access changed the register");

  a_miss_error: assert property (@(posedge clock) disable iff (!rst_n)
    psel && penable && !pready && !hit |=> pslverr && pready)
    else $error("Unmapped access without error");

  a_hit_no_error: assert property (@(posedge clock) disable iff (!rst_n)
    psel && penable && !pready && hit |=> !pslverr && pready)
    else $error("Mapped access answered with error");

  a_strobe_keep: assert property (@(posedge clock) disable iff (!rst_n)
    finish && pwrite && hit && !pstrb[1] |=> cfg_ff[15:8] == $past(cfg_ff[15:8]))
    else $error("Upper lane written without its strobe");

  a_reset_outputs: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> posRoute[POS_TEMP] && negAuto && !stepEnable && gainSelect == GAIN_X1)
    else $error("Decode outputs left reset wrong");

  a_read_value: assert property (@(posedge clock) disable iff (!rst_n)
    psel && penable && !pready && hit && !pwrite |=> prdata == {16'h0000, $past(cfg_ff)})
    else $error("Read data not the register value");

  a_write_rdata_zero: assert property (@(posedge clock) disable iff (!rst_n)
    psel && penable && !pready && pwrite |=> prdata == 32'h0000_0000)
    else $error("Write answered with nonzero data");

  a_reserved_store: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_ff[RSVD_HI:RSVD_LO] == 8'h00)
    else $error("Reserved bits stored");

  a_enable_reg: assert property (@(posedge clock) disable iff (!rst_n)
    stepEnable == cfg_ff[ENABLE_BIT])
    else $error("Step enable differs from bit 15");

  a_enable_stable: assert property (@(posedge clock) disable iff (!rst_n)
    !(finish && pwrite && hit) |=> $stable(stepEnable))
    else $error("Step enable moved without a write");

  a_gain_two: assert property (@(posedge clock) disable iff (!rst_n)
    gainSelect == GAIN_X2 |-> cfg_ff[GAIN_HI:GAIN_LO] == GAIN_CODE_X2)
    else $error("Gain 2 without code 01");

  a_gain_legal: assert property (@(posedge clock) disable iff (!rst_n)
    gainSelect != 2'h3)
    else $error("Illegal gain output");

  a_neg_ground: assert property (@(posedge clock) disable iff (!rst_n)
    !negAuto && !cfg_ff[NEG_BIT] |-> !negExtSeven)
    else $error("Negative input not on analog ground");

  a_neg_seven_set: assert property (@(posedge clock) disable iff (!rst_n)
    !negAuto && cfg_ff[NEG_BIT] |-> negExtSeven)
    else $error("Negative input seven not selected");

  a_ext_inputs: assert property (@(posedge clock) disable iff (!rst_n)
    !cfg_ff[POS_HI] |-> posRoute[7:0] != 8'h00 && posRoute[15:8] == 8'h00 && !negAuto)
    else $error("External code not routed to an input");

  a_temp_code: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_ff[POS_HI:POS_LO] == POS_TEMP |-> posRoute[POS_TEMP] && !negExtSeven)
    else $error("Temperature code misrouted");

  a_short_code: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_ff[POS_HI:POS_LO] == POS_SHORT |-> posRoute[POS_SHORT] && negAuto)
    else $error("Short code misrouted");

  a_test_dac: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_ff[POS_HI:POS_LO] == POS_TEST_DAC |-> posRoute[POS_TEST_DAC] && negAuto)
    else $error("Test source code misrouted");

  a_supply_analog: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_ff[POS_HI:POS_LO] == POS_AVDD_DIV4 |-> posRoute[POS_AVDD_DIV4] && negAuto)
    else $error("Analog supply code misrouted");

  a_power_inputs: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_ff[POS_HI:POS_LO] >= POS_ANALOG_PWR_DIV |-> posRoute[15:14] != 2'h0 && negAuto)
    else $error("Power input code misrouted");

  a_io_supply: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_ff[POS_HI:POS_LO] == POS_IOVDD_DIV4 |-> posRoute[POS_IOVDD_DIV4] && negAuto)
    else $error("IO supply code misrouted");

  // Code 1101 has its own tag, POS_DVDD_DIV2, and must still force the negative input
  a_digital_half: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_ff[POS_HI:POS_LO] == POS_DVDD_DIV2 |-> posRoute[POS_DVDD_DIV2] && negAuto)
    else $error("Digital supply code misrouted");

endmodule

// file: dv/adc_sequencer_step8_config_bench.sv
// Bench for the step eight configuration register over APB
`timescale 1ns/100ps

module adc_sequencer_step8_config_bench;
  import ascfg_pkg::*;
  logic        clock, rst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, stepEnable, negAuto, negExtSeven, err;
  logic [1:0]  gainSelect;
  logic [15:0] posRoute, d;
  int          miscompares, total_checks;

  ascfg_step8_config ascfg_step8_config_inst (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .stepEnable(stepEnable),
    .gainSelect(gainSelect), .negAuto(negAuto), .negExtSeven(negExtSeven),
    .posRoute(posRoute));

  // ----------------------------------------------------------------
  // Clock, compare and closing
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // APB transfer; answer taken at the edge where pready is high
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd; pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = 4'h0; miscompares = 0; total_checks = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk("posRoute rst", 32'h0100, {16'h0, posRoute});
    chk("negAuto rst", 32'h1, {31'h0, negAuto});
    apb(1'b0, 12'h260, 32'h0, 4'hf);
    chk("read rst", 32'h0008, rd);
    for (int i = 0; i < 16; i++) begin
      d = {i[0], i[2:1], 8'hff, i[1], i[3:0]};
      apb(1'b1, 12'h260, {16'hffff, d}, 4'hf);
      chk("stepEnable", {31'h0, i[0]}, {31'h0, stepEnable});
      chk("gainSelect", (i[2:1] == 2'h0) ? 0 : (i[2:1] == 2'h1) ? 1 : 2,
          {30'h0, gainSelect});
      chk("posRoute", 32'h1 << i[3:0], {16'h0, posRoute});
      chk("negAuto", {31'h0, i[3]}, {31'h0, negAuto});
      chk("negExtSeven", {31'h0, i[1] & ~i[3]}, {31'h0, negExtSeven});
      apb(1'b0, 12'h260, 32'h0, 4'hf);
      chk("read back", {16'h0, d & 16'he01f}, rd);
    end
    apb(1'b1, 12'h264, 32'h0, 4'hf);
    chk("pslverr wr", 32'h1, {31'h0, err});
    apb(1'b0, 12'h264, 32'h0, 4'hf);
    chk("unmapped rd", 32'h0, rd);
    apb(1'b1, 12'h260, 32'h0, 4'h2);
    apb(1'b0, 12'h260, 32'h0, 4'hf);
    chk("strobe read", 32'h001f, rd);
    chk("pslverr ok", 32'h0, {31'h0, err});
    results();
  end
endmodule
